// ### rtl/srpg_cfg.svh
// constants for the receive override and pattern generator block
`ifndef SRPG_CFG_SVH
`define SRPG_CFG_SVH
`define SRPG_ADDR_W 12
`define SRPG_RXO_OFF 12'h008
`define SRPG_PGC_OFF 12'h00C
`define SRPG_STAT_OFF 12'h010
`define SRPG_RXO_EN_BIT 14
`define SRPG_LOS_HI 13
`define SRPG_LOS_LO 12
`define SRPG_EQ_HI 7
`define SRPG_EQ_LO 5
`define SRPG_ALIGN_BIT 3
`define SRPG_HALF_BIT 0
`define SRPG_RXO_RST 32'h0000_101E
`define SRPG_RXO_WMASK 32'h0000_7FFF
`define SRPG_RXO_NOVR 32'h0000_1008
`define SRPG_PAT_HI 29
`define SRPG_PAT_LO 20
`define SRPG_ERR_BIT 19
`define SRPG_MODE_HI 18
`define SRPG_MODE_LO 16
`define SRPG_PGC_RST 32'h0000_0000
`define SRPG_LOS_STAT_BIT 2
`define SRPG_LOS_CNT 8'h80
`define SRPG_LFSR_SEED 15'h7FFF
`endif

// ### rtl/srpg_pkg.sv
// types for the receive override and pattern generator block
package srpg_pkg;
	typedef enum logic [1:0] {
		SRPG_LOS_OFF = 2'h0,
		SRPG_LOS_RSV1 = 2'h1,
		SRPG_LOS_RSV2 = 2'h2,
		SRPG_LOS_HEAVY = 2'h3
	} srpg_los_e;
	typedef enum logic [2:0] {
		SRPG_GEN_OFF = 3'h0,
		SRPG_GEN_L15 = 3'h1,
		SRPG_GEN_L7 = 3'h2,
		SRPG_GEN_FIX = 3'h3,
		SRPG_GEN_BAL = 3'h4,
		SRPG_GEN_FRM = 3'h5,
		SRPG_GEN_RS6 = 3'h6,
		SRPG_GEN_RS7 = 3'h7
	} srpg_gen_e;
	typedef struct packed {
		logic [1:0] signal_loss_filter_sel;
		logic [2:0] rx_equalizer_code;
		logic align_en;
		logic half_rate;
	} srpg_rxset_s;
	typedef struct packed {
		logic [11:0] addr;
		logic [31:0] wdata;
		logic wr;
		logic rd;
	} srpg_req_s;
endpackage

// ### rtl/srpg_gen.sv
// pattern word generator feeding the transmit serializer
`timescale 1ns/1ps
`include "srpg_cfg.svh"
module srpg_gen #(
	parameter int W = 10
) (
	// clock and reset
	input wire logic clk,
	input wire logic nrst,
	// control
	input wire logic [2:0] mode,
	input wire logic [W-1:0] gen_pattern_word,
	input wire logic err_req,
	// output word
	output logic [W-1:0] word_q,
	output logic err_done
);
	import srpg_pkg::*;
	logic [14:0] lfsr_q;
	logic [14:0] lfsr_d;
	logic [1:0] phase_q;
	logic [2:0] mode_q;
	logic [W-1:0] word_d;
	logic [W-1:0] lfsr_bits;
	logic restart;
	// the lfsr and framing logic are sized for ten-bit words only
	if (W != 10) begin : g_bad_width
		$error("srpg_gen serves only 10-bit words");
	end
	assign restart = (mode != mode_q);
	// step the lfsr ten bits per word, one bit per loop pass
	// the word collects the ten new bits, oldest in the msb, so the
	// short lfsr still fills all ten bits of the word
	always_comb begin
		lfsr_d = lfsr_q;
		lfsr_bits = {W{1'b0}};
		for (int i = 0; i < W; i++) begin
			if (srpg_gen_e'(mode_q) == SRPG_GEN_L7)
				lfsr_d = {8'h00, lfsr_d[5:0], lfsr_d[6] ^ lfsr_d[5]};
			else
				lfsr_d = {lfsr_d[13:0], lfsr_d[14] ^ lfsr_d[13]};
			lfsr_bits = {lfsr_bits[W-2:0], lfsr_d[0]};
		end
	end
	// sequence state restarts on any mode change
	always_ff @(posedge clk or negedge nrst) begin
		if (!nrst) begin
			lfsr_q <= `SRPG_LFSR_SEED;
			phase_q <= 2'h0;
			mode_q <= 3'h0;
		end else begin
			mode_q <= mode;
			if (restart) begin
				lfsr_q <= `SRPG_LFSR_SEED;
				phase_q <= 2'h0;
			end else begin
				lfsr_q <= lfsr_d;
				phase_q <= phase_q + 2'h1;
			end
		end
	end
	// word select; reserved modes send zeros like disabled
	always_comb begin
		unique case (srpg_gen_e'(mode_q))
			SRPG_GEN_L15: word_d = lfsr_bits;
			SRPG_GEN_L7: word_d = lfsr_bits;
			SRPG_GEN_FIX: word_d = gen_pattern_word;
			SRPG_GEN_BAL:
				word_d = phase_q[0] ? ~gen_pattern_word
					: gen_pattern_word;
			SRPG_GEN_FRM: begin
				unique case (phase_q)
					2'h0: word_d = {W{1'b0}};
					2'h1: word_d = gen_pattern_word;
					2'h2: word_d = {W{1'b1}};
					default: word_d = ~gen_pattern_word;
				endcase
			end
			default: word_d = {W{1'b0}};
		endcase
	end
	// a restart zeroes the word, so the error waits one cycle for it
	assign err_done = err_req && !restart;
	// one word per clock; error flips the lsb once
	always_ff @(posedge clk or negedge nrst) begin
		if (!nrst)
			word_q <= {W{1'b0}};
		else if (restart)
			word_q <= {W{1'b0}};
		else
			word_q <= word_d ^ {{(W-1){1'b0}}, err_done};
	end
	frame_restart_a: assert property (@(posedge clk) disable iff (!nrst)
		restart |=> word_q == '0)
		else $error("word not cleared on mode change");
	fixed_word_a: assert property (@(posedge clk) disable iff (!nrst)
		mode_q == 3'h3 && !restart && !err_req |=>
		word_q == $past(gen_pattern_word))
		else $error("fixed word mismatch");
endmodule

// ### rtl/srpg_top.sv
// receive override and pattern generator control registers
`timescale 1ns/1ps
`include "srpg_cfg.svh"
module srpg_top #(
	parameter int LOS_N = 128
) (
	// clock and reset
	input wire logic CLK_SYS,
	input wire logic NRST,
	// register port
	input wire logic [`SRPG_ADDR_W-1:0] ADDR,
	input wire logic [31:0] WDATA,
	input wire logic WR,
	input wire logic RD,
	output logic [31:0] RDATA,
	// receive side
	input wire logic RX_SIGNAL_PRESENT,
	input wire srpg_pkg::srpg_rxset_s RX_STATUS_SET,
	output srpg_pkg::srpg_rxset_s RX_APPLIED_SET,
	output logic SIGNAL_LOSS_FLAG,
	// transmit side
	output logic [9:0] TX_WORD
);
	import srpg_pkg::*;
	logic [31:0] rxo_q;
	logic [31:0] pgc_q;
	logic [31:0] rdata_d;
	logic [7:0] los_cnt_q;
	logic los_q;
	logic raw_loss;
	logic err_done;
	logic ovr_en;
	srpg_rxset_s ovr_set;
	srpg_los_e los_sel;
	// the eight-bit counter also relies on this range
	if (LOS_N < 123 || LOS_N > 133) begin : g_bad_los
		$error("loss count outside 128 +/- 5");
	end
	// receive override register; preserve bits below bit 15 kept as written, bits 31:15 stay zero
	always_ff @(posedge CLK_SYS or negedge NRST) begin
		if (!NRST)
			rxo_q <= `SRPG_RXO_RST;
		else if (WR && ADDR == `SRPG_RXO_OFF)
			rxo_q <= WDATA & `SRPG_RXO_WMASK | rxo_q & ~`SRPG_RXO_WMASK;
	end
	// generator control; trigger self-clears once the error is sent
	always_ff @(posedge CLK_SYS or negedge NRST) begin
		if (!NRST)
			pgc_q <= `SRPG_PGC_RST;
		else if (WR && ADDR == `SRPG_PGC_OFF)
			pgc_q <= {2'h0, WDATA[`SRPG_PAT_HI:`SRPG_MODE_LO], 16'h0000};
		else if (err_done)
			pgc_q[`SRPG_ERR_BIT] <= 1'b0;
	end
	assign ovr_en = rxo_q[`SRPG_RXO_EN_BIT];
	assign ovr_set = '{
		signal_loss_filter_sel: rxo_q[`SRPG_LOS_HI:`SRPG_LOS_LO],
		rx_equalizer_code: rxo_q[`SRPG_EQ_HI:`SRPG_EQ_LO],
		align_en: rxo_q[`SRPG_ALIGN_BIT],
		half_rate: rxo_q[`SRPG_HALF_BIT]};
	// overrides win only while enabled
	assign RX_APPLIED_SET = ovr_en ? ovr_set : RX_STATUS_SET;
	assign los_sel = srpg_los_e'(RX_APPLIED_SET.signal_loss_filter_sel);
	assign raw_loss = !RX_SIGNAL_PRESENT;
	// loss filter; clock is taken as the prescaler output clock
	always_ff @(posedge CLK_SYS or negedge NRST) begin
		if (!NRST) begin
			los_cnt_q <= 8'h00;
			los_q <= 1'b0;
		end else if (los_sel == SRPG_LOS_HEAVY) begin
			if (!raw_loss) begin
				los_cnt_q <= 8'h00;
				los_q <= 1'b0;
			end else if (los_cnt_q == 8'(LOS_N - 1)) begin
				los_q <= 1'b1;
			end else begin
				// a flag left from passthrough must not skip the count
				los_cnt_q <= los_cnt_q + 8'h01;
				los_q <= 1'b0;
			end
		end else begin
			// disabled and reserved codes pass the raw level
			los_cnt_q <= 8'h00;
			los_q <= raw_loss;
		end
	end
	assign SIGNAL_LOSS_FLAG = los_q;
	// readback mux
	always_comb begin
		rdata_d = 32'h0000_0000;
		unique case (ADDR)
			`SRPG_RXO_OFF: rdata_d = rxo_q;
			`SRPG_PGC_OFF: rdata_d = pgc_q;
			`SRPG_STAT_OFF: rdata_d[`SRPG_LOS_STAT_BIT] = los_q;
			default: rdata_d = 32'h0000_0000;
		endcase
	end
	always_ff @(posedge CLK_SYS or negedge NRST) begin
		if (!NRST)
			RDATA <= 32'h0000_0000;
		else if (RD)
			RDATA <= rdata_d;
		else
			RDATA <= 32'h0000_0000;
	end
	srpg_gen #(
		.W(10)
	) u_gen (
		.clk(CLK_SYS),
		.nrst(NRST),
		.mode(pgc_q[`SRPG_MODE_HI:`SRPG_MODE_LO]),
		.gen_pattern_word(pgc_q[`SRPG_PAT_HI:`SRPG_PAT_LO]),
		.err_req(pgc_q[`SRPG_ERR_BIT]),
		.word_q(TX_WORD),
		.err_done(err_done)
	);
	override_mux_a: assert property (@(posedge CLK_SYS) disable iff (!NRST)
		!ovr_en |-> RX_APPLIED_SET == RX_STATUS_SET)
		else $error("override applied while disabled");
	heavy_count_a: assert property (@(posedge CLK_SYS) disable iff (!NRST)
		los_sel == SRPG_LOS_HEAVY && los_cnt_q < 8'(LOS_N - 1)
		&& raw_loss |=> !los_q)
		else $error("loss flag too early");
	heavy_clear_a: assert property (@(posedge CLK_SYS) disable iff (!NRST)
		los_sel == SRPG_LOS_HEAVY && !raw_loss |=> !los_q)
		else $error("loss flag stuck with signal");
	err_once_a: assert property (@(posedge CLK_SYS) disable iff (!NRST)
		err_done && !WR |=> !pgc_q[`SRPG_ERR_BIT])
		else $error("error trigger not cleared");
	stat_read_a: assert property (@(posedge CLK_SYS) disable iff (!NRST)
		RD && ADDR == `SRPG_STAT_OFF |=> RDATA[2] == $past(los_q))
		else $error("status loss bit wrong");
	pgc_resv_a: assert property (@(posedge CLK_SYS) disable iff (!NRST)
		pgc_q[15:0] == 16'h0000 && pgc_q[31:30] == 2'h0)
		else $error("reserved generator bits set");
	rxo_hold_a: assert property (@(posedge CLK_SYS) disable iff (!NRST)
		!(WR && ADDR == `SRPG_RXO_OFF) |=> $stable(rxo_q))
		else $error("override register changed without write");
endmodule

// ### tb/tb_top.sv
// self-checking bench for the receive override and pattern generator block
`timescale 1ns/1ps
`include "srpg_cfg.svh"
module tb_top;
	import srpg_pkg::*;
	logic clk_sys = 1'b0;
	logic nrst = 1'b0;
	logic [11:0] addr = 12'h000;
	logic [31:0] wdata = 32'h0000_0000;
	logic wr = 1'b0;
	logic rd = 1'b0;
	logic [31:0] rdata;
	logic sig_ok = 1'b1;
	srpg_rxset_s st_set = 7'h2A;
	srpg_rxset_s ap_set;
	logic loss;
	logic [9:0] tx;
	int bad_count = 0;
	int cmp_count = 0;
	localparam logic [9:0] PAT = 10'h2B5;
	// preserve-type bits of the override register
	localparam logic [31:0] KEEP = 32'hFFFF_8F16;
	srpg_top #(.LOS_N(128)) dut (.CLK_SYS(clk_sys), .NRST(nrst),
		.ADDR(addr), .WDATA(wdata), .WR(wr), .RD(rd), .RDATA(rdata),
		.RX_SIGNAL_PRESENT(sig_ok), .RX_STATUS_SET(st_set),
		.RX_APPLIED_SET(ap_set), .SIGNAL_LOSS_FLAG(loss), .TX_WORD(tx));
	// free running 100 MHz clock
	always #5 clk_sys = ~clk_sys;
	task chk(input string n, input logic [31:0] e, input logic [31:0] g);
		cmp_count++;
		if (g !== e) begin
			$display("ERROR %s expected %h seen %h", n, e, g);
			bad_count++;
		end
	endtask
	// one-cycle write strobe, released on the following edge
	task wr_reg(input logic [11:0] a, input logic [31:0] d);
		@(posedge clk_sys);
		addr <= a;
		wdata <= d;
		wr <= 1'b1;
		@(posedge clk_sys);
		wr <= 1'b0;
	endtask
	// read data stand only in the cycle after the strobe is taken
	task rd_reg(input logic [11:0] a, output logic [31:0] d);
		@(posedge clk_sys);
		addr <= a;
		rd <= 1'b1;
		@(posedge clk_sys);
		rd <= 1'b0;
		#1 d = rdata;
	endtask
	task cyc(input int n);
		repeat (n) @(posedge clk_sys);
		#1;
	endtask
	// software writes back the preserve bits it has read
	task rxo_set(input logic [31:0] f);
		logic [31:0] d;
		rd_reg(`SRPG_RXO_OFF, d);
		wr_reg(`SRPG_RXO_OFF, d & KEEP | f);
	endtask
	task t_reset_regs;
		logic [31:0] d;
		rd_reg(`SRPG_RXO_OFF, d);
		chk("rx override reset", `SRPG_RXO_RST, d);
		rd_reg(`SRPG_PGC_OFF, d);
		chk("generator reset", 32'h0000_0000, d);
		rd_reg(12'h040, d);
		chk("unmapped read", 32'h0000_0000, d);
		chk("applied no override", {25'h0, st_set}, {25'h0, ap_set});
	endtask
	task t_override;
		logic [31:0] d;
		rxo_set(32'h0000_40A1);
		cyc(1);
		chk("applied override", 32'h15, {25'h0, ap_set});
		rxo_set(32'h0000_00A1);
		cyc(1);
		chk("applied released", {25'h0, st_set}, {25'h0, ap_set});
		rd_reg(`SRPG_RXO_OFF, d);
		chk("preserve bits kept", 32'h0000_00B7, d);
	endtask
	// gen reg image for a mode and pattern, trigger optional
	function automatic logic [31:0] pg(logic [2:0] m, logic e);
		return {2'h0, PAT, e, m, 16'h0000};
	endfunction
	task t_fixed_and_error;
		int n;
		logic [31:0] d;
		wr_reg(`SRPG_PGC_OFF, pg(3'h3, 1'b0));
		cyc(4);
		chk("fixed word", {22'h0, PAT}, {22'h0, tx});
		wr_reg(`SRPG_PGC_OFF, pg(3'h3, 1'b1));
		n = 0;
		repeat (8) begin
			cyc(1);
			if (tx === (PAT ^ 10'h001)) n++;
		end
		chk("single error count", 32'h1, n);
		chk("after error word", {22'h0, PAT}, {22'h0, tx});
		rd_reg(`SRPG_PGC_OFF, d);
		chk("trigger cleared", pg(3'h3, 1'b0), d);
	endtask
	task t_balanced;
		logic [9:0] w0;
		wr_reg(`SRPG_PGC_OFF, pg(3'h4, 1'b0));
		cyc(4);
		w0 = tx;
		cyc(1);
		chk("balanced pair", {22'h0, ~w0}, {22'h0, tx});
		chk("balanced word", 32'h1, (w0 === PAT) || (w0 === ~PAT));
	endtask
	// the restart word and the first framed word are both zero,
	// so the sequence is timed from the write, not searched for
	task t_framed;
		wr_reg(`SRPG_PGC_OFF, pg(3'h5, 1'b0));
		cyc(2);
		chk("framed start", 32'h0, {22'h0, tx});
		cyc(1);
		chk("framed word 1", {22'h0, PAT}, {22'h0, tx});
		cyc(1);
		chk("framed word 2", 32'h3FF, {22'h0, tx});
		cyc(1);
		chk("framed word 3", {22'h0, ~PAT}, {22'h0, tx});
		cyc(1);
		chk("framed word 0", 32'h0, {22'h0, tx});
	endtask
	// reference stream from the taps: seed all ones, ten steps a word,
	// oldest bit of the word in the msb
	function automatic logic [9:0] lfsr_word(logic [2:0] m, int n);
		logic [14:0] s;
		logic [9:0] w;
		logic b;
		s = `SRPG_LFSR_SEED;
		w = 10'h000;
		for (int i = 0; i < 10 * n; i++) begin
			b = (m == 3'h2) ? s[6] ^ s[5] : s[14] ^ s[13];
			s = {s[13:0], b};
			w = {w[8:0], b};
		end
		return w;
	endfunction
	task t_modes;
		logic [9:0] w0;
		logic [2:0] m;
		for (int k = 0; k < 3; k++) begin
			m = (k == 0) ? 3'h0 : 3'h5 + k[2:0];
			wr_reg(`SRPG_PGC_OFF, pg(m, 1'b0));
			cyc(5);
			chk("idle mode word", 32'h0, {22'h0, tx});
		end
		for (int k = 1; k < 3; k++) begin
			m = k[2:0];
			wr_reg(`SRPG_PGC_OFF, pg(m, 1'b0));
			cyc(5);
			w0 = tx;
			chk("lfsr w4", {22'h0, lfsr_word(m, 4)}, {22'h0, w0});
			cyc(1);
			chk("lfsr w5", {22'h0, lfsr_word(m, 5)}, {22'h0, tx});
			chk("lfsr advances", 32'h1, (w0 !== tx) && (tx !== 10'h000));
		end
	endtask
	task t_loss;
		int n;
		logic [31:0] d;
		rxo_set(32'h0000_7008);
		sig_ok <= 1'b0;
		n = 0;
		while (loss !== 1'b1 && n < 300) begin
			cyc(1);
			n++;
		end
		chk("heavy loss delay", 32'h1, (n >= 123) && (n <= 133));
		rd_reg(`SRPG_STAT_OFF, d);
		chk("status loss bit", 32'h1, {31'h0, d[2]});
		rxo_set(32'h0000_4008);
		sig_ok <= 1'b1;
		cyc(4);
		chk("unfiltered clear", 32'h0, {31'h0, loss});
		@(posedge clk_sys);
		sig_ok <= 1'b0;
		cyc(4);
		chk("unfiltered set", 32'h1, {31'h0, loss});
	endtask
	task end_of_test;
		if (bad_count == 0 && cmp_count > 0) begin
			$display("Regression OK");
		end else begin
			$display("Regression broken");
		end
		$finish;
	endtask
	// watchdog: the sequence needs well under 2000 cycles
	initial begin
		#200000;
		bad_count++;
		end_of_test();
	end
	initial begin
		repeat (20) @(posedge clk_sys);
		nrst <= 1'b1;
		t_reset_regs();
		t_override();
		t_fixed_and_error();
		t_balanced();
		t_framed();
		t_modes();
		t_loss();
		end_of_test();
	end
endmodule
